// ### logic/spip_cfg.svh
// Constants of the serial peripheral pin block: word size, control bit
// positions, FIFO depth and master timing counts.
// Assumes a single include per compile unit; the guard keeps it safe.
`ifndef SPIP_CFG_SVH
`define SPIP_CFG_SVH

// ----------------------------------------------------------------------
// Word and counters
// ----------------------------------------------------------------------
`define SPIP_WORD_BITS 8
`define SPIP_CNT_W 3
`define SPIP_EDGE_W 5
`define SPIP_LAST_EDGE 5'h0F
`define SPIP_DIV_W 8
`define SPIP_FIFO_DEPTH 16
// Pin synchroniser reset: select high, slave-out high, done toggle low
`define SPIP_PIN_IDLE 3'h6

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define SPIP_CTL_ENABLE 0
`define SPIP_CTL_MASTER 1
`define SPIP_CTL_CPOL 2
`define SPIP_CTL_CPHA 3
`define SPIP_CTL_ODRAIN 4
`define SPIP_CTL_DIS 5

`endif

// ### logic/spip_pkg.sv
// Types shared by the serial peripheral pin block.
// Assumes spip_cfg.svh is on the include path.
`include "spip_cfg.svh"

package spip_pkg;

   // Received or transmitted word
   typedef logic [`SPIP_WORD_BITS-1:0] spip_word_t;

   // Master sequencer states
   typedef enum logic [1:0] {
      SPIP_M_IDLE,
      SPIP_M_RUN,
      SPIP_M_TAIL
   } spip_mstate_e;

endpackage : spip_pkg

// ### logic/spip_sync.sv
// Two-flop level synchroniser, one per bit.
// Assumes the inputs are levels that stay put for several destination clocks.
`timescale 1ns/1ps

module spip_sync #(
   parameter int WIDTH = 1,
   // Reset value; match each input's idle level to avoid a false edge
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // First stage is read only by the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule : spip_sync

// ### logic/spip_fifo.sv
// Synchronous FIFO built from flip-flops, valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock domain.
`timescale 1ns/1ps

module spip_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Full when pointers differ only in the wrap bit
   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage, one flop row per entry
   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_entry
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               mem[i] <= '0;
            end else if (push && (wr_ptr[AW-1:0] == AW'(i))) begin
               mem[i] <= in_data;
            end
         end
      end
   endgenerate

endmodule : spip_fifo

// ### logic/spip_top.sv
// Serial peripheral port at pin level: master sequencer on the core clock,
// slave shifter on the incoming shift clock, receive FIFO toward the user.
// Assumes the control register is a plain port held static while enabled,
// and that two-way pins are resolved outside from the active-low enables.
`timescale 1ns/1ps
`include "spip_cfg.svh"

module spip_top
   import spip_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control register and master rate
   input wire logic [7:0] serial_control_reg,
   input wire logic [`SPIP_DIV_W-1:0] clk_div,
   input wire logic err_clear,
   // Transmit word
   input wire logic [`SPIP_WORD_BITS-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_taken,
   // Receive words
   output logic [`SPIP_WORD_BITS-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   // Status
   output logic busy,
   output logic multimaster_error,
   output logic rx_overflow,
   // Shift clock pin
   input wire logic serial_shift_clock_in,
   output logic serial_shift_clock_out,
   output logic serial_shift_clock_oe_n,
   // Slave select pin
   input wire logic slave_select_in_n,
   // Master-out pin
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_n,
   // Slave-out pin
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_n
);

   // ----------------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------------
   // format from polarity and phase
   wire ctl_en = serial_control_reg[`SPIP_CTL_ENABLE];
   wire ctl_master = serial_control_reg[`SPIP_CTL_MASTER];
   wire ctl_cpol = serial_control_reg[`SPIP_CTL_CPOL];
   wire ctl_cpha = serial_control_reg[`SPIP_CTL_CPHA];
   wire ctl_odrain = serial_control_reg[`SPIP_CTL_ODRAIN];
   wire ctl_dis = serial_control_reg[`SPIP_CTL_DIS];
   wire master_on = ctl_en & ctl_master;

   // ----------------------------------------------------------------------
   // Pin synchronisers (core domain)
   // ----------------------------------------------------------------------
   logic ss_n_s;
   logic miso_s;
   logic done_tgl_s;
   logic done_tgl_l;

   // Reset to idle levels, else a deselected pin reads as select after reset
   spip_sync #(.WIDTH(3), .RST_VAL(`SPIP_PIN_IDLE)) u_pin_sync (
      .clk(core_clk),
      .rstn(rstn),
      .d({slave_select_in_n, miso_in, done_tgl_l}),
      .q({ss_n_s, miso_s, done_tgl_s})
   );

   // ----------------------------------------------------------------------
   // Registered mode flags
   // ----------------------------------------------------------------------
   logic slave_on;
   logic clk_inv;

   // Flops so the link reset and clock inversion come glitch free
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         slave_on <= 1'b0;
         clk_inv <= 1'b0;
      end else begin
         slave_on <= ctl_en & ~ctl_master;
         clk_inv <= ctl_cpol ^ ctl_cpha;
      end
   end

   // ----------------------------------------------------------------------
   // Slave link domain
   // ----------------------------------------------------------------------
   // inverting the pin clock puts every format's sample on a rise
   wire link_clk = serial_shift_clock_in ^ clk_inv;
   // select high holds the link logic in reset
   wire link_rstn = rstn & ~slave_select_in_n & slave_on;

   logic [`SPIP_CNT_W-1:0] l_cnt;
   spip_word_t l_rx_sr;
   spip_word_t l_rx_hold;
   logic l_out_bit;
   logic l_launched;
   spip_word_t slave_tx;

   // master-out pin is the slave's sample input
   wire [`SPIP_WORD_BITS-1:0] l_rx_next = {l_rx_sr[`SPIP_WORD_BITS-2:0], mosi_in};

   // Sample edge: shift in, hand a full word over
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         l_cnt <= '0;
         l_rx_sr <= '0;
      end else begin
         l_cnt <= l_cnt + 1'b1;
         l_rx_sr <= l_rx_next;
      end
   end

   // Word handover; hold and toggle keep their value across selections
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         l_rx_hold <= '0;
         done_tgl_l <= 1'b0;
      end else if (link_rstn && (l_cnt == `SPIP_CNT_W'(`SPIP_WORD_BITS - 1))) begin
         l_rx_hold <= l_rx_next;
         done_tgl_l <= ~done_tgl_l;
      end
   end

   always_ff @(negedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         l_out_bit <= 1'b1;
         l_launched <= 1'b0;
      end else begin
         l_out_bit <= slave_tx[`SPIP_CNT_W'(`SPIP_WORD_BITS - 1) - l_cnt];
         l_launched <= 1'b1;
      end
   end

   // First bit must stand before any edge when phase is zero
   wire slave_bit = l_launched ? l_out_bit : slave_tx[`SPIP_WORD_BITS-1];

   // slave-out transmits only in slave mode
   // disable bit releases it for broadcast
   // releasing the line leaves it to the one chosen slave
   // open drain drives only the low level
   assign miso_out = ctl_odrain ? 1'b0 : slave_bit;
   assign miso_oe_n = ~link_rstn | ctl_dis | (ctl_odrain & slave_bit);

   // ----------------------------------------------------------------------
   // Receive FIFO
   // ----------------------------------------------------------------------
   logic fifo_in_valid;
   logic fifo_in_ready;
   spip_word_t fifo_in_data;

   spip_fifo #(.WIDTH(`SPIP_WORD_BITS), .DEPTH(`SPIP_FIFO_DEPTH)) u_rx_fifo (
      .clk(core_clk),
      .rstn(rstn),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in_data),
      .in_ready(fifo_in_ready),
      .out_valid(rx_valid),
      .out_data(rx_data),
      .out_ready(rx_ready)
   );

   // ----------------------------------------------------------------------
   // Slave word collection (core domain)
   // ----------------------------------------------------------------------
   logic done_seen;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         done_seen <= 1'b0;
      end else begin
         done_seen <= done_tgl_s;
      end
   end

   // Hold word is stable for a whole word time after the toggle moves
   wire slave_push = slave_on & (done_tgl_s ^ done_seen);
   wire slave_load = slave_on & ss_n_s & tx_valid & ~tx_taken;

   // Slave transmit word changes only while deselected
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         slave_tx <= '1;
      end else if (slave_load) begin
         slave_tx <= tx_data;
      end
   end

   // ----------------------------------------------------------------------
   // Master sequencer
   // ----------------------------------------------------------------------
   spip_mstate_e state;
   spip_mstate_e next_state;
   logic [`SPIP_DIV_W-1:0] div_cnt;
   logic [`SPIP_EDGE_W-1:0] edge_cnt;
   spip_word_t tx_sr;
   spip_word_t rx_sr;
   logic mm_err;

   // low select while master is another master
   wire mm_set = master_on & ~ss_n_s;
   wire half_tick = (div_cnt == clk_div);
   wire last_edge = (edge_cnt == `SPIP_LAST_EDGE);
   // phase picks which half of each bit samples
   wire sample_now = (edge_cnt[0] == ctl_cpha);
   wire run_tick = (state == SPIP_M_RUN) & half_tick;
   // Back-pressure: no word starts unless the FIFO can take its reply
   wire start = (state == SPIP_M_IDLE) & master_on & tx_valid & ~tx_taken
                & fifo_in_ready & ~mm_err & ~mm_set;
   wire master_push = (state == SPIP_M_TAIL) & half_tick;

   // Sequencer next state; an error aborts any word
   always_comb begin
      next_state = state;
      unique case (state)
         SPIP_M_IDLE: begin
            if (start) next_state = SPIP_M_RUN;
         end
         SPIP_M_RUN: begin
            if (run_tick && last_edge) next_state = SPIP_M_TAIL;
         end
         SPIP_M_TAIL: begin
            if (half_tick) next_state = SPIP_M_IDLE;
         end
      endcase
      if (mm_err || mm_set || !master_on) next_state = SPIP_M_IDLE;
   end

   // State and half-period divider
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= SPIP_M_IDLE;
         div_cnt <= '0;
      end else begin
         state <= next_state;
         div_cnt <= (half_tick || state == SPIP_M_IDLE) ? '0 : div_cnt + 1'b1;
      end
   end

   // clock toggles once per edge count, then rests
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         serial_shift_clock_out <= 1'b0;
         edge_cnt <= '0;
      end else if (run_tick) begin
         serial_shift_clock_out <= ~serial_shift_clock_out;
         edge_cnt <= edge_cnt + 1'b1;
      end else if (state != SPIP_M_RUN) begin
         serial_shift_clock_out <= ctl_cpol;
         edge_cnt <= '0;
      end
   end

   // Phase one launches on the first edge, phase zero before it
   wire [`SPIP_WORD_BITS-1:0] tx_first = ctl_cpha ? tx_data : {tx_data[`SPIP_WORD_BITS-2:0], 1'b0};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_sr <= '0;
         mosi_out <= 1'b1;
      end else if (start) begin
         tx_sr <= tx_first;
         mosi_out <= tx_data[`SPIP_WORD_BITS-1];
      end else if (run_tick && !sample_now) begin
         tx_sr <= {tx_sr[`SPIP_WORD_BITS-2:0], 1'b0};
         mosi_out <= tx_sr[`SPIP_WORD_BITS-1];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_sr <= '0;
      end else if (run_tick && sample_now) begin
         rx_sr <= {rx_sr[`SPIP_WORD_BITS-2:0], miso_s};
      end
   end

   // ----------------------------------------------------------------------
   // FIFO feed and pin enables
   // ----------------------------------------------------------------------
   assign fifo_in_valid = master_push | slave_push;
   assign fifo_in_data = master_push ? rx_sr : l_rx_hold;

   // master drives clock and master-out; error releases both
   wire drive_master = master_on & ~mm_err & ~mm_set;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         serial_shift_clock_oe_n <= 1'b1;
         mosi_oe_n <= 1'b1;
      end else begin
         serial_shift_clock_oe_n <= ~drive_master;
         mosi_oe_n <= ~drive_master;
      end
   end

   // ----------------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------------
   // sticky error; a new event beats a clear in the same cycle
   assign multimaster_error = mm_err;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mm_err <= 1'b0;
      end else begin
         mm_err <= mm_set | (mm_err & ~err_clear);
      end
   end

   // Slave words cannot be stalled, so a full FIFO loses them
   wire ovf_set = slave_push & ~fifo_in_ready;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_overflow <= 1'b0;
      end else begin
         rx_overflow <= ovf_set | (rx_overflow & ~err_clear);
      end
   end

   // Word taken and busy indication
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_taken <= 1'b0;
         busy <= 1'b0;
      end else begin
         tx_taken <= start | slave_load;
         busy <= (next_state != SPIP_M_IDLE) | (slave_on & ~ss_n_s);
      end
   end

endmodule : spip_top

// ### testbench/spip_checker.sv
// Core-clock assertions on the serial pin block's ports.
// Assumes one core clock domain; link-side timing is judged at the pins.
`timescale 1ns/1ps

module spip_checker (
   // Clock, reset, control
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] serial_control_reg,
   // Status
   input wire logic tx_taken,
   input wire logic busy,
   input wire logic multimaster_error,
   // Pins
   input wire logic slave_select_in_n,
   input wire logic serial_shift_clock_out,
   input wire logic serial_shift_clock_oe_n,
   input wire logic mosi_out,
   input wire logic mosi_oe_n,
   input wire logic miso_out,
   input wire logic miso_oe_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   logic mst;
   logic [4:0] n_edge;

   // Enabled master mode
   assign mst = serial_control_reg[0] && serial_control_reg[1];

   // Driven shift clock toggles since the last accepted word
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         n_edge <= 5'h00;
      end else if (tx_taken) begin
         n_edge <= 5'h00;
      end else if ($changed(serial_shift_clock_out) && !serial_shift_clock_oe_n) begin
         n_edge <= n_edge + 5'h01;
      end
   end

   // Low select held for three core-clock samples, through both synchroniser stages
   sequence s_mm_seen;
      (mst && !slave_select_in_n)[*3];
   endsequence

   sequence s_sample_edge;
      $changed(serial_shift_clock_out) && !mosi_oe_n &&
      ((serial_shift_clock_out != serial_control_reg[2]) != serial_control_reg[3]);
   endsequence

   a_sck_rest_level: assert property (
      !busy && !serial_shift_clock_oe_n && $stable(serial_control_reg)
      |-> serial_shift_clock_out == serial_control_reg[2])
      else $error("shift clock not at rest level while idle");
   a_sck_edge_count: assert property (
      $fell(busy) && mst && !multimaster_error |-> n_edge == 5'h10)
      else $error("word did not carry sixteen clock edges");
   a_mosi_hold_sample: assert property (
      s_sample_edge |-> $stable(mosi_out))
      else $error("master-out changed on a sample edge");
   a_miso_in_master: assert property (
      mst |-> miso_oe_n)
      else $error("slave-out driven in master mode");
   a_mosi_in_slave: assert property (
      serial_control_reg[0] && !serial_control_reg[1] && $stable(serial_control_reg)
      |-> mosi_oe_n)
      else $error("master-out driven in slave mode");
   a_miso_unselected: assert property (
      slave_select_in_n |-> miso_oe_n)
      else $error("slave-out driven while not selected");
   a_miso_disabled: assert property (
      serial_control_reg[5] |-> miso_oe_n)
      else $error("slave-out driven while disabled");
   a_open_drain_low: assert property (
      serial_control_reg[4] && !miso_oe_n |-> !miso_out)
      else $error("open-drain slave-out drove high");
   a_mm_error_flag: assert property (
      s_mm_seen |=> multimaster_error)
      else $error("multimaster error not flagged");
   a_mm_pin_release: assert property (
      multimaster_error |=> serial_shift_clock_oe_n && mosi_oe_n)
      else $error("pins still driven after multimaster error");
endmodule : spip_checker

bind spip_top spip_checker u_chk (
   .core_clk(core_clk),
   .rstn(rstn),
   .serial_control_reg(serial_control_reg),
   .tx_taken(tx_taken),
   .busy(busy),
   .multimaster_error(multimaster_error),
   .slave_select_in_n(slave_select_in_n),
   .serial_shift_clock_out(serial_shift_clock_out),
   .serial_shift_clock_oe_n(serial_shift_clock_oe_n),
   .mosi_out(mosi_out),
   .mosi_oe_n(mosi_oe_n),
   .miso_out(miso_out),
   .miso_oe_n(miso_oe_n)
);

// ### testbench/spip_peer.sv
// Far serial party: master for slave-mode runs, slave for master-mode runs.
// Assumes the bench resolves shared pins from all enables and pull-ups.
`timescale 1ns/1ps

module spip_peer (
   // Role and format
   input wire logic is_master,
   input wire logic clr,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] so_word,
   // Resolved pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   // Drives
   output logic sck_o,
   output logic sel_n,
   output logic mosi_o,
   output logic mosi_oe,
   output logic so_o,
   output logic so_oe,
   output logic [7:0] got
);
   int e = 0;
   int idx;

   initial begin
      sck_o = 1'b0;
      sel_n = 1'b1;
      mosi_o = 1'b0;
      mosi_oe = 1'b0;
      got = 8'h00;
   end

   // drive slave-out only as sole slave, launch edge only
   assign idx = (e - int'(cpha)) / 2;
   assign so_oe = !is_master && !clr && e >= int'(cpha) && idx < 8;
   assign so_o = so_word[3'(7 - idx)];

   // sample master-out on the opposite edge; a new frame restarts the count
   always @(sck or posedge clr) begin
      if (clr) begin
         e = 0;
      end else if (!is_master) begin
         if ((sck != cpol) != cpha) begin
            got = {got[6:0], mosi};
         end
         e = e + 1;
      end
   end

   // one 12 ns clock per bit, still outside the word
   task automatic xfer(input logic [7:0] tx, input logic sel);
      sck_o = cpol;
      #20 sel_n = !sel;
      mosi_oe = 1'b1;
      #20;
      for (int i = 7; i >= 0; i--) begin
         if (!cpha) mosi_o = tx[i];
         #6 sck_o = !cpol;
         if (!cpha) got = {got[6:0], miso};
         #1 if (cpha) mosi_o = tx[i];
         #5 sck_o = cpol;
         if (cpha) got = {got[6:0], miso};
      end
      #20 sel_n = 1'b1;
      mosi_oe = 1'b0;
   endtask : xfer
endmodule : spip_peer

// ### testbench/spip_top_tb.sv
// Self-checking bench of the serial pin block in master and slave roles.
// Assumes the peer model on the pins and pull-ups on every shared line.
`timescale 1ns/1ps

module spip_top_tb
   import spip_pkg::*;
;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] ctl = 8'h03;
   logic err_clear = 1'b0;
   spip_word_t tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic mm_low = 1'b0;
   logic p_clr = 1'b1;
   logic [7:0] so_word = 8'h00;
   int n_mismatch = 0;
   int comparisons = 0;
   spip_word_t rx_data;
   logic tx_taken, rx_valid, busy, mm_err, ovf, sck_o, sck_oe_n;
   logic mosi_o, mosi_oe_n, miso_o, miso_oe_n;
   logic p_sck, p_sel_n, p_mosi, p_mosi_oe, p_so, p_so_oe;
   logic [7:0] p_got;
   wire sck = !sck_oe_n ? sck_o : !ctl[1] ? p_sck : 1'b1;
   wire mosi = !mosi_oe_n ? mosi_o : p_mosi_oe ? p_mosi : 1'b1;
   wire miso = !miso_oe_n ? miso_o : p_so_oe ? p_so : 1'b1;
   wire sel_n = p_sel_n && !mm_low;

   always #25 core_clk = ~core_clk;

   spip_top dut (.core_clk(core_clk), .rstn(rstn), .serial_control_reg(ctl),
      .clk_div(8'h03), .err_clear(err_clear), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .busy(busy), .multimaster_error(mm_err), .rx_overflow(ovf),
      .serial_shift_clock_in(sck), .serial_shift_clock_out(sck_o),
      .serial_shift_clock_oe_n(sck_oe_n), .slave_select_in_n(sel_n), .mosi_in(mosi),
      .mosi_out(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_in(miso), .miso_out(miso_o),
      .miso_oe_n(miso_oe_n));

   spip_peer peer (.is_master(!ctl[1]), .clr(p_clr), .cpol(ctl[2]), .cpha(ctl[3]),
      .so_word(so_word), .sck(sck), .mosi(mosi), .miso(miso), .sck_o(p_sck),
      .sel_n(p_sel_n), .mosi_o(p_mosi), .mosi_oe(p_mosi_oe), .so_o(p_so),
      .so_oe(p_so_oe), .got(p_got));

   // ----------------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------------
   task automatic chk8(input string what, input spip_word_t exp, input spip_word_t got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chk1(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   task automatic final_report;
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // Bounded wait on a status output; a timeout ends the run
   task automatic wait_hi(input string what, input int sel);
      int n;
      n = 0;
      while (((sel == 0) ? rx_valid : (sel == 1) ? tx_taken : !busy) !== 1'b1) begin
         tick(1);
         n++;
         if (n > 400) begin
            n_mismatch++;
            $display("[ERR] %s expected 1 seen timeout", what);
            final_report();
         end
      end
   endtask : wait_hi

   task automatic pop(input spip_word_t exp);
      wait_hi("rx_valid", 0);
      chk8("rx_data", exp, rx_data);
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
      tick(1);
   endtask : pop

   // Master word: let the last word end, fresh peer frame, hold until taken
   task automatic mword(input spip_word_t tx, input logic [7:0] ret);
      wait_hi("busy low", 2);
      p_clr = 1'b1;
      so_word = ret;
      tx_data = tx;
      tick(1);
      p_clr = 1'b0;
      tx_valid = 1'b1;
      wait_hi("tx_taken", 1);
      tx_valid = 1'b0;
   endtask : mword

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset;
      tick(2);
      chk1("sck_oe_n", 1'b1, sck_oe_n);
      chk1("mosi_oe_n", 1'b1, mosi_oe_n);
      chk1("rx_valid", 1'b0, rx_valid);
      tick(2);
      rstn = 1'b1;
      tick(3);
      $display("reset done");
   endtask : t_reset

   task automatic t_master(input logic [1:0] m);
      ctl = {4'h0, m, 2'b11};
      tick(4);
      mword(8'hA5 ^ {6'h00, m}, 8'h3C + {6'h00, m});
      pop(8'h3C + {6'h00, m});
      wait_hi("busy low", 2);
      chk8("peer got", 8'hA5 ^ {6'h00, m}, p_got);
      chk1("sck rest", m[0], sck_o);
      $display("master format %0d done", m);
   endtask : t_master

   task automatic t_fill;
      ctl = 8'h03;
      tick(4);
      for (int i = 0; i < 16; i++) mword(8'h00, 8'h10 + 8'(i));
      wait_hi("busy low", 2);
      tx_valid = 1'b1;
      tick(100);
      chk1("tx_taken full", 1'b0, tx_taken);
      tx_valid = 1'b0;
      ctl = 8'h01;
      tick(4);
      peer.xfer(8'hE7, 1'b1);
      tick(10);
      chk1("rx_overflow", 1'b1, ovf);
      for (int i = 0; i < 16; i++) pop(8'h10 + 8'(i));
      chk1("rx_valid empty", 1'b0, rx_valid);
      $display("fifo fill done");
   endtask : t_fill

   task automatic t_slave(input logic [7:0] c, input spip_word_t tx, input logic [7:0] exp);
      ctl = c;
      tx_data = tx;
      tx_valid = 1'b1;
      wait_hi("tx_taken slave", 1);
      tx_valid = 1'b0;
      tick(4);
      peer.xfer(8'h5A ^ c, 1'b1);
      pop(8'h5A ^ c);
      chk8("peer got", exp, p_got);
      tick(6);
      $display("slave ctl %h done", c);
   endtask : t_slave

   task automatic t_mm;
      ctl = 8'h03;
      tick(4);
      mm_low = 1'b1;
      tick(6);
      chk1("mm error", 1'b1, mm_err);
      chk1("sck_oe_n", 1'b1, sck_oe_n);
      mm_low = 1'b0;
      tick(4);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      tick(1);
      chk1("mm cleared", 1'b0, mm_err);
      chk1("ovf cleared", 1'b0, ovf);
      $display("multimaster done");
   endtask : t_mm

   task automatic t_unsel;
      ctl = 8'h01;
      tick(4);
      peer.xfer(8'h77, 1'b0);
      tick(20);
      chk1("rx_valid unselected", 1'b0, rx_valid);
      chk8("peer got unselected", 8'hFF, p_got);
      $display("unselected done");
   endtask : t_unsel

   initial begin
      t_reset();
      for (int m = 0; m < 4; m++) t_master(2'(m));
      t_fill();
      for (int m = 0; m < 4; m++) t_slave(8'h01 | 8'(m << 2), 8'hC3, 8'hC3);
      t_slave(8'h11, 8'h96, 8'h96);
      t_slave(8'h21, 8'h96, 8'hFF);
      t_unsel();
      t_mm();
      final_report();
   end
endmodule : spip_top_tb
